//--- logic/pcx_pkg.sv
`default_nettype none
package pcx_pkg;
   // Register addresses in bank 1.
   localparam logic [7:0] PCX_ADDR_PIN_CFG = 8'hE9;
   localparam logic [7:0] PCX_ADDR_IRQ_CFG = 8'hEB;
   localparam logic [7:0] PCX_RESET_VAL    = 8'h00;
   localparam int         PCX_FIELD_W      = 2;
   localparam int         PCX_NPINS        = 4;
   // The interrupt pins sit above the four configurable low pins.
   localparam int         PCX_IRQ_PIN_LO   = 4;
   // Output enables idle high, so every low pin floats as an input out of reset.
   localparam logic [3:0] PCX_OE_N_IDLE    = 4'hF;
   // Pin configuration field codes.
   localparam logic [1:0] PCX_PIN_SCHMITT  = 2'h0;
   localparam logic [1:0] PCX_PIN_SERIAL   = 2'h1;
   localparam logic [1:0] PCX_PIN_LCD      = 2'h2;
   localparam logic [1:0] PCX_PIN_PUSHPULL = 2'h3;
   // Interrupt edge field codes.
   localparam logic [1:0] PCX_IRQ_OFF      = 2'h0;
   localparam logic [1:0] PCX_IRQ_FALL     = 2'h1;
   localparam logic [1:0] PCX_IRQ_RISE     = 2'h2;
   localparam logic [1:0] PCX_IRQ_BOTH     = 2'h3;
endpackage : pcx_pkg
`default_nettype wire

//--- logic/pcx_port3_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module pcx_port3_cfg (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       bank1_sel,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [3:0] spi_out,
   input  wire logic [3:0] spi_oe,
   input  wire logic [3:0] lcd_seg,
   input  wire logic [3:0] port_data_out,
   input  wire logic [7:0] pin_in,
   output logic      [3:0] pin_out,
   output logic      [3:0] pin_oe_n,
   output logic      [3:0] irq_edge_pulse
);
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [7:0] pin_cfg_r;
      logic [7:0] irq_cfg_r;
      logic [7:0] rdata_r;
      logic [3:0] out_r;
      logic [3:0] oe_n_r;
      logic [3:0] in_s1;
      logic [3:0] in_s2;
      logic [3:0] in_d;
      logic [3:0] pulse_r;
   } pcx_state_s;

   pcx_state_s st_r;
   pcx_state_s st_nxt;
   logic       rst_n_int;
   logic       hit_pin;
   logic       hit_irq;

   // Address decode; a read needs only bank1_sel and the address, a write also needs the strobe.
   assign rst_n_int = st_r.rst_sync[1];
   assign hit_pin   = bank1_sel && (reg_addr == pcx_pkg::PCX_ADDR_PIN_CFG);
   assign hit_irq   = bank1_sel && (reg_addr == pcx_pkg::PCX_ADDR_IRQ_CFG);

   // Edge qualifier per interrupt field code.
   function automatic logic pcx_edge_hit(input logic [1:0] code, input logic prev,
                                         input logic cur);
      logic fall;
      logic rise;
      fall = prev && !cur;
      rise = !prev && cur;
      case (code)
         pcx_pkg::PCX_IRQ_FALL: pcx_edge_hit = fall;
         pcx_pkg::PCX_IRQ_RISE: pcx_edge_hit = rise;
         pcx_pkg::PCX_IRQ_BOTH: pcx_edge_hit = fall || rise;
         default:               pcx_edge_hit = 1'b0;
      endcase
   endfunction : pcx_edge_hit

   // Next-state logic; pins are synchronised before edge detection.
   always_comb begin
      st_nxt          = st_r;
      st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
      st_nxt.in_s1    = pin_in[pcx_pkg::PCX_IRQ_PIN_LO +: pcx_pkg::PCX_NPINS];
      st_nxt.in_s2    = st_r.in_s1;
      st_nxt.in_d     = st_r.in_s2;
      if (reg_wr && hit_pin) begin
         st_nxt.pin_cfg_r = reg_wdata;
      end else if (reg_wr && hit_irq) begin
         st_nxt.irq_cfg_r = reg_wdata;
      end
      // Unmapped addresses read as zero.
      if (hit_pin) begin
         st_nxt.rdata_r = st_r.pin_cfg_r;
      end else if (hit_irq) begin
         st_nxt.rdata_r = st_r.irq_cfg_r;
      end else begin
         st_nxt.rdata_r = pcx_pkg::PCX_RESET_VAL;
      end
      for (int i = 0; i < pcx_pkg::PCX_NPINS; i++) begin
         case (st_r.pin_cfg_r[i*pcx_pkg::PCX_FIELD_W +: pcx_pkg::PCX_FIELD_W])
            pcx_pkg::PCX_PIN_SERIAL: begin
               st_nxt.out_r[i]  = spi_out[i];
               st_nxt.oe_n_r[i] = !spi_oe[i];
            end
            pcx_pkg::PCX_PIN_LCD: begin
               st_nxt.out_r[i]  = lcd_seg[i];
               st_nxt.oe_n_r[i] = 1'b0;
            end
            pcx_pkg::PCX_PIN_PUSHPULL: begin
               st_nxt.out_r[i]  = port_data_out[i];
               st_nxt.oe_n_r[i] = 1'b0;
            end
            default: begin
               st_nxt.out_r[i]  = 1'b0;
               st_nxt.oe_n_r[i] = 1'b1;
            end
         endcase
         st_nxt.pulse_r[i] = pcx_edge_hit(
            st_r.irq_cfg_r[i*pcx_pkg::PCX_FIELD_W +: pcx_pkg::PCX_FIELD_W],
            st_r.in_d[i], st_r.in_s2[i]);
      end
   end

   // Every register takes the async reset; all but the reset synchroniser are also held by the released copy.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '{oe_n_r: pcx_pkg::PCX_OE_N_IDLE, default: '0};
      end else if (!rst_n_int) begin
         st_r <= '{rst_sync: st_nxt.rst_sync,
                   oe_n_r:   pcx_pkg::PCX_OE_N_IDLE,
                   default:  '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Every output is a bare register bit, so no decode glitch can reach a pin.
   assign reg_rdata      = st_r.rdata_r;
   assign pin_out        = st_r.out_r;
   assign pin_oe_n       = st_r.oe_n_r;
   assign irq_edge_pulse = st_r.pulse_r;

   property p_pin_write;
      @(posedge ref_clk) disable iff (!rst_n_int)
         reg_wr && hit_pin |=> st_r.pin_cfg_r == $past(reg_wdata);
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("pin cfg write lost");

   property p_irq_write;
      @(posedge ref_clk) disable iff (!rst_n_int)
         reg_wr && hit_irq |=> st_r.irq_cfg_r == $past(reg_wdata);
   endproperty
   a_irq_write: assert property (p_irq_write) else $error("irq cfg write lost");

   property p_pushpull;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.pin_cfg_r[1:0] == pcx_pkg::PCX_PIN_PUSHPULL && $stable(st_r.pin_cfg_r)
         |=> !pin_oe_n[0] && pin_out[0] == $past(port_data_out[0]);
   endproperty
   a_pushpull: assert property (p_pushpull) else $error("push-pull not driven");

   property p_schmitt;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.pin_cfg_r[7:6] == pcx_pkg::PCX_PIN_SCHMITT |=> pin_oe_n[3];
   endproperty
   a_schmitt: assert property (p_schmitt) else $error("input pin driven");

   property p_irq_off;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.irq_cfg_r[1:0] == pcx_pkg::PCX_IRQ_OFF |=> !irq_edge_pulse[0];
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("disabled irq fired");

   property p_rise;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.irq_cfg_r[3:2] == pcx_pkg::PCX_IRQ_RISE && !st_r.in_d[1] && st_r.in_s2[1]
         |=> irq_edge_pulse[1];
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge missed");

   property p_fall_only;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.irq_cfg_r[5:4] == pcx_pkg::PCX_IRQ_FALL && !st_r.in_d[2] |=> !irq_edge_pulse[2];
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("falling mode misfired");

   property p_reset_clear;
      @(posedge ref_clk) !rst_n_int |-> st_r.pin_cfg_r == pcx_pkg::PCX_RESET_VAL
         && st_r.irq_cfg_r == pcx_pkg::PCX_RESET_VAL;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset not cleared");

   // A level change on a pin once it has left the synchroniser.
   sequence s_toggled(prev, cur);
      prev != cur;
   endsequence

   // A high-to-low change once it has left the synchroniser.
   sequence s_fell(prev, cur);
      prev && !cur;
   endsequence

   // A write that turns pin 3 into a push-pull output.
   sequence s_pin3_pp_write;
      reg_wr && hit_pin && reg_wdata[7:6] == pcx_pkg::PCX_PIN_PUSHPULL;
   endsequence

   // With both edges enabled, any change of pin 7 must reach its pulse.
   property p_both_edge;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.irq_cfg_r[7:6] == pcx_pkg::PCX_IRQ_BOTH
         ##0 s_toggled(st_r.in_d[3], st_r.in_s2[3])
         |=> irq_edge_pulse[3];
   endproperty
   a_both_edge: assert property (p_both_edge) else $error("either edge missed");

   // In falling mode a high-to-low change of pin 6 must reach its pulse.
   property p_fall_pulse;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.irq_cfg_r[5:4] == pcx_pkg::PCX_IRQ_FALL
         ##0 s_fell(st_r.in_d[2], st_r.in_s2[2])
         |=> irq_edge_pulse[2];
   endproperty
   a_fall_pulse: assert property (p_fall_pulse) else $error("falling edge missed");

   // A pulse is only ever the echo of a level change one cycle earlier.
   property p_pulse_cause;
      @(posedge ref_clk) disable iff (!rst_n_int)
         irq_edge_pulse != 4'h0
         |-> (irq_edge_pulse & ~$past(st_r.in_d ^ st_r.in_s2)) == 4'h0;
   endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without edge");

   // Two steps: the write lands, then the pin drives the port latch.
   property p_pp_after_write;
      @(posedge ref_clk) disable iff (!rst_n_int)
         s_pin3_pp_write ##1 !(reg_wr && hit_pin)
         |=> !pin_oe_n[3] && pin_out[3] == $past(port_data_out[3]);
   endproperty
   a_pp_after_write: assert property (p_pp_after_write) else $error("push-pull late");

   // An LCD segment pin always drives, whatever the segment level.
   property p_lcd_drive;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.pin_cfg_r[5:4] == pcx_pkg::PCX_PIN_LCD
         |=> !pin_oe_n[2] && pin_out[2] == $past(lcd_seg[2]);
   endproperty
   a_lcd_drive: assert property (p_lcd_drive) else $error("segment not driven");

   // A serial pin drives only while the peripheral asks for it.
   property p_serial_drive;
      @(posedge ref_clk) disable iff (!rst_n_int)
         st_r.pin_cfg_r[3:2] == pcx_pkg::PCX_PIN_SERIAL
         |=> pin_oe_n[1] == !$past(spi_oe[1]);
   endproperty
   a_serial_drive: assert property (p_serial_drive) else $error("serial enable wrong");

   // Unmapped addresses and the other bank read back as zero.
   property p_unmapped_read;
      @(posedge ref_clk) disable iff (!rst_n_int)
         !hit_pin && !hit_irq |=> reg_rdata == pcx_pkg::PCX_RESET_VAL;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");
endmodule : pcx_port3_cfg
`default_nettype wire

//--- verification/pcx_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pins of port 3: high pins follow the levels asked for, low pins echo the drive.
module pcx_pin_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] hi_lvl,
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe_n,
   output logic      [3:0] unused_lo,
   output logic      [7:0] pin_in
);
   logic tog = 1'b0;
   // An undriven low pin changes every cycle, so a stale value is never mistaken for drive.
   always_ff @(posedge ref_clk) begin
      tog <= ~tog;
   end
   assign unused_lo = pin_oe_n & {4{tog}};
   assign pin_in    = {hi_lvl, unused_lo | (~pin_oe_n & pin_out)};
endmodule : pcx_pin_model
`default_nettype wire

//--- verification/pcx_port3_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcx_port3_cfg_tb;
   logic       ref_clk, nrst, bank1_sel, reg_wr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in;
   logic [3:0] spi_out, spi_oe, lcd_seg, port_data_out, pin_out, pin_oe_n, irq_edge_pulse;
   logic [3:0] hi_lvl, seen, e_oen, e_out;
   int         fail_count = 0, num_checks = 0, cyc = 0;
   pcx_port3_cfg u_dut (.ref_clk(ref_clk), .nrst(nrst), .bank1_sel(bank1_sel),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .spi_out(spi_out), .spi_oe(spi_oe), .lcd_seg(lcd_seg), .port_data_out(port_data_out),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_edge_pulse(irq_edge_pulse));
   pcx_pin_model u_pins (.ref_clk(ref_clk), .hi_lvl(hi_lvl), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .unused_lo(), .pin_in(pin_in));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // A hang is cut short well past the 80 or so cycles the tests need.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         end_sim();
      end
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task end_sim;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // Inputs move 1 ns after the edge; a write leaves the strobe up so writes may follow back to back.
   task step(input int n);
      reg_wr = 1'b0;
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task wr(input logic [7:0] a, input logic [7:0] d, input logic b);
      reg_addr  = a;
      reg_wdata = d;
      bank1_sel = b;
      reg_wr    = 1'b1;
      @(posedge ref_clk);
      #1;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      reg_wr    = 1'b0;
      reg_addr  = a;
      bank1_sel = 1'b1;
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, e);
   endtask : rd
   // Drive and enable expected per pin field; a Schmitt input's level is not compared.
   task pcheck(input logic [7:0] cfg);
      wr(pcx_pkg::PCX_ADDR_PIN_CFG, cfg, 1'b1);
      step(2);
      for (int i = 0; i < 4; i++) begin
         case (cfg[2*i+:2])
            pcx_pkg::PCX_PIN_SCHMITT: begin
               e_oen[i] = 1'b1;
               e_out[i] = 1'b0;
            end
            pcx_pkg::PCX_PIN_SERIAL: begin
               e_oen[i] = ~spi_oe[i];
               e_out[i] = spi_out[i];
            end
            pcx_pkg::PCX_PIN_LCD: begin
               e_oen[i] = 1'b0;
               e_out[i] = lcd_seg[i];
            end
            default: begin
               e_oen[i] = 1'b0;
               e_out[i] = port_data_out[i];
            end
         endcase
      end
      chk({4'h0, pin_oe_n}, {4'h0, e_oen});
      chk({4'h0, pin_out & ~e_oen}, {4'h0, e_out & ~e_oen});
   endtask : pcheck
   task collect(input logic [3:0] lvl, input logic [7:0] e);
      seen = 4'h0;
      hi_lvl = lvl;
      repeat (6) begin
         step(1);
         seen = seen | irq_edge_pulse;
      end
      chk({4'h0, seen}, e);
   endtask : collect
   task edges(input logic [7:0] cfg, input logic [7:0] er, input logic [7:0] ef);
      wr(pcx_pkg::PCX_ADDR_IRQ_CFG, cfg, 1'b1);
      collect(4'hF, er);
      collect(4'h0, ef);
   endtask : edges
   initial begin
      nrst          = 1'b0;
      bank1_sel     = 1'b0;
      reg_addr      = 8'h00;
      reg_wr        = 1'b0;
      reg_wdata     = 8'h00;
      spi_out       = 4'hA;
      spi_oe        = 4'h6;
      lcd_seg       = 4'h5;
      port_data_out = 4'hC;
      hi_lvl        = 4'h0;
      step(16);
      nrst = 1'b1;
      step(3);
      chk({4'h0, pin_oe_n}, 8'h0F);
      rd(pcx_pkg::PCX_ADDR_PIN_CFG, 8'h00);
      rd(pcx_pkg::PCX_ADDR_IRQ_CFG, 8'h00);
      wr(pcx_pkg::PCX_ADDR_PIN_CFG, 8'h5A, 1'b1);
      wr(pcx_pkg::PCX_ADDR_IRQ_CFG, 8'hC3, 1'b1);
      wr(8'hEA, 8'hFF, 1'b1);
      wr(pcx_pkg::PCX_ADDR_PIN_CFG, 8'hFF, 1'b0);
      rd(pcx_pkg::PCX_ADDR_PIN_CFG, 8'h5A);
      rd(pcx_pkg::PCX_ADDR_IRQ_CFG, 8'hC3);
      rd(8'hEA, 8'h00);
      pcheck(8'hE4);
      pcheck(8'h1B);
      pcheck(8'h55);
      pcheck(8'hAA);
      pcheck(8'hFF);
      pcheck(8'h00);
      edges(8'hE4, 8'h0C, 8'h0A);
      edges(8'h1B, 8'h03, 8'h05);
      // A reset in mid-run must clear registers that hold non-zero values.
      wr(pcx_pkg::PCX_ADDR_PIN_CFG, 8'hFF, 1'b1);
      nrst = 1'b0;
      step(2);
      nrst = 1'b1;
      step(3);
      chk({4'h0, pin_oe_n}, 8'h0F);
      rd(pcx_pkg::PCX_ADDR_PIN_CFG, 8'h00);
      rd(pcx_pkg::PCX_ADDR_IRQ_CFG, 8'h00);
      end_sim();
   end
endmodule : pcx_port3_cfg_tb
`default_nettype wire
